/* rtl/bit_sync.sv */
// Two flip-flop synchroniser for a level
`timescale 1ns/1ps
module bit_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // bit_sync

/* rtl/can_mode_ctrl.sv */
// CAN mode control and acceptance mask register block on APB
`timescale 1ns/1ps
module can_mode_ctrl
  import can_mode_pkg::*;
#(
  parameter int tx_buffers = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state from outside the clock domain
  input wire logic device_idle,
  // Transmit buffers
  input wire logic [tx_buffers-1:0] tx_pending,
  output logic tx_abort,
  // Receive and acceptance
  input wire logic rx_done,
  input wire logic [mask_width-1:0] msg_addr,
  input wire logic [mask_width-1:0] filter_addr,
  output logic accept_hit,
  output logic rx_capture_event,
  // Mode outputs to the controller core
  output logic [mode_width-1:0] current_op_mode,
  output logic controller_halt,
  output logic filter_window
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic access_phase = psel & penable;
  wire logic wr_en = access_phase & pwrite;
  wire logic sel_ctrl = (paddr == ctrl_one_offset);
  wire logic sel_mask = (paddr == mask_offset);
  wire logic sel_pend = (paddr == pending_offset);
  wire logic mapped = sel_ctrl | sel_mask | sel_pend;
  wire logic wr_ctrl_lo = wr_en & sel_ctrl & pstrb[0];
  wire logic wr_ctrl_hi = wr_en & sel_ctrl & pstrb[1];
  wire logic wr_mask_lo = wr_en & sel_mask & pstrb[0];
  wire logic wr_mask_hi = wr_en & sel_mask & pstrb[1];

  // ****************************************
  // Control state
  // ****************************************
  logic stop_idle_q;
  logic abort_q, abort_d;
  logic [mode_width-1:0] req_mode_q;
  logic [mode_width-1:0] cur_mode_q, cur_mode_d;
  logic capture_en_q;
  logic window_q;
  logic [mask_width-1:0] mask_q;
  logic [2:0] settle_q, settle_d;
  logic idle_sync;
  logic halt_d;
  logic accept_d;
  logic cap_d;
  logic [31:0] rdata_d;

  bit_sync u_idle_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(device_idle),
    .q(idle_sync)
  );

  mask_compare #(.width(mask_width)) u_cmp (
    .msg_addr(msg_addr),
    .filter_addr(filter_addr),
    .mask(mask_q),
    .hit(accept_d)
  );

  // Writing one starts abort; clears once no buffer pending
  wire logic abort_set = wr_ctrl_hi & pwdata[abort_pos];
  wire logic all_aborted = (tx_pending == '0);
  // Set wins over the self clear
  assign abort_d = abort_set | (abort_q & ~all_aborted);

  // Mode change: count settle cycles, then report
  wire logic mode_differs = (cur_mode_q != req_mode_q);
  always_comb begin
    settle_d = settle_q;
    cur_mode_d = cur_mode_q;
    if (!mode_differs) begin
      settle_d = 3'd0;
    end else if (settle_q == 3'(mode_settle_cycles - 1)) begin
      cur_mode_d = req_mode_q;
      settle_d = 3'd0;
    end else begin
      settle_d = settle_q + 3'd1;
    end
  end

  assign halt_d = stop_idle_q & idle_sync;
  assign cap_d = capture_en_q & rx_done & ~halt_d;

  // Read data; unimplemented bits stay zero
  wire logic [15:0] ctrl_view = {2'b00, stop_idle_q, abort_q, 1'b0, req_mode_q,
                                 cur_mode_q, 1'b0, capture_en_q, 2'b00,
                                 window_q};
  wire logic [15:0] mask_view = {6'h00, mask_q};
  wire logic [31:0] pend_view = 32'(tx_pending);
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel_ctrl) begin
      rdata_d = {16'h0000, ctrl_view};
    end else if (sel_mask) begin
      rdata_d = {16'h0000, mask_view};
    end else if (sel_pend) begin
      rdata_d = pend_view;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_idle_q <= ctrl_reset[stop_idle_pos];
      req_mode_q <= mode_config;
      capture_en_q <= ctrl_reset[capture_pos];
      window_q <= ctrl_reset[window_pos];
    end else begin
      if (wr_ctrl_hi) begin
        stop_idle_q <= pwdata[stop_idle_pos];
        req_mode_q <= pwdata[req_mode_lsb +: mode_width];
      end
      if (wr_ctrl_lo) begin
        capture_en_q <= pwdata[capture_pos];
        window_q <= pwdata[window_pos];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= mask_reset;
    end else begin
      if (wr_mask_lo) begin
        mask_q[7:0] <= pwdata[7:0];
      end
      if (wr_mask_hi) begin
        mask_q[9:8] <= pwdata[9:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_q <= 1'b0;
      cur_mode_q <= mode_config;
      settle_q <= 3'd0;
    end else begin
      abort_q <= abort_d;
      cur_mode_q <= cur_mode_d;
      settle_q <= settle_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_abort <= 1'b0;
      controller_halt <= 1'b0;
      accept_hit <= 1'b0;
      rx_capture_event <= 1'b0;
      current_op_mode <= mode_config;
      filter_window <= 1'b0;
    end else begin
      tx_abort <= abort_d;
      controller_halt <= halt_d;
      accept_hit <= accept_d;
      rx_capture_event <= cap_d;
      current_op_mode <= cur_mode_d;
      filter_window <= window_q;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= rdata_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_mask_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_mask) |=> (prdata[31:10] == 22'h0))
    else $error("mask upper bits not zero");

  chk_ctrl_unimpl_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_ctrl) |=>
      (prdata[15:14] == 2'b00 && prdata[4] == 1'b0 && prdata[2:1] == 2'b00))
    else $error("unimplemented control bits not zero");

  chk_abort_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (abort_q && all_aborted && !abort_set) |=> !abort_q)
    else $error("abort not cleared after transmits aborted");

  chk_abort_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (abort_q && !all_aborted) |=> (abort_q && tx_abort))
    else $error("abort dropped while transmit pending");

  chk_halt_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stop_idle_q && idle_sync) |=> controller_halt)
    else $error("no halt in idle with stop bit set");

  chk_run_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !stop_idle_q |=> !controller_halt)
    else $error("halted although stop bit clear");

  chk_capture_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_capture_event |-> $past(capture_en_q) && $past(rx_done))
    else $error("capture event without enable");

  chk_mode_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    ($changed(req_mode_q) && mode_differs) |-> ##[1:6] (cur_mode_q == req_mode_q))
    else $error("current mode did not follow request");

  chk_mode_stable: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(mode_differs) |-> $stable(cur_mode_q))
    else $error("current mode changed with no request");

  chk_accept_mask: assert property (
    @(posedge pclk) disable iff (!presetn)
    (((msg_addr ^ filter_addr) & ~mask_q) == '0) |=> accept_hit)
    else $error("masked address not accepted");

  chk_accept_miss: assert property (
    @(posedge pclk) disable iff (!presetn)
    (((msg_addr ^ filter_addr) & ~mask_q) != '0) |=> !accept_hit)
    else $error("unmasked address difference accepted");

  // ****************************************
  // Write and readback checks, with settle, halt and capture checks
  // ****************************************
  chk_mask_lo_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_mask_lo |=> (mask_q[7:0] == $past(pwdata[7:0])))
    else $error("mask low byte not written");

  chk_mask_hi_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_mask_hi |=> (mask_q[9:8] == $past(pwdata[9:8])))
    else $error("mask high bits not written");

  chk_mask_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_mask) |=> (prdata[mask_width-1:0] == $past(mask_q)))
    else $error("mask read data wrong");

  chk_req_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl_hi |=> (req_mode_q == $past(pwdata[req_mode_lsb +: mode_width])))
    else $error("requested mode not written");

  chk_req_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_ctrl) |=>
      (prdata[req_mode_lsb +: mode_width] == $past(req_mode_q)))
    else $error("requested mode read data wrong");

  chk_mode_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_ctrl) |=>
      (prdata[cur_mode_lsb +: mode_width] == $past(cur_mode_q)))
    else $error("current mode read data wrong");

  chk_mode_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_differs && (settle_q != 3'(mode_settle_cycles - 1))) |=> $stable(cur_mode_q))
    else $error("current mode changed before settling");

  chk_stop_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl_hi |=> (stop_idle_q == $past(pwdata[stop_idle_pos])))
    else $error("stop in idle bit not written");

  chk_halt_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    !idle_sync |=> !controller_halt)
    else $error("halted although device not idle");

  chk_abort_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    abort_set |=> (abort_q && tx_abort))
    else $error("abort write not taken");

  chk_abort_readback: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & ~penable & sel_ctrl) |=> (prdata[abort_pos] == $past(abort_q)))
    else $error("abort read data wrong");

  chk_capture_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl_lo |=> (capture_en_q == $past(pwdata[capture_pos])))
    else $error("capture enable not written");

  chk_capture_fire: assert property (
    @(posedge pclk) disable iff (!presetn)
    (capture_en_q && rx_done && !halt_d) |=> rx_capture_event)
    else $error("no capture event on enabled receive");

  chk_window_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl_lo |=> (window_q == $past(pwdata[window_pos])))
    else $error("window bit not written");

  chk_window_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl_lo |=> ##1 (filter_window == $past(pwdata[window_pos], 2)))
    else $error("window output does not follow bit");

endmodule // can_mode_ctrl

/* rtl/can_mode_pkg.sv */
// Constants for the CAN mode-control and acceptance-mask block
package can_mode_pkg;
  // Register byte addresses
  localparam logic [11:0] ctrl_one_offset = 12'h000;
  localparam logic [11:0] mask_offset = 12'h004;
  localparam logic [11:0] pending_offset = 12'h008;
  // Field positions in the control register, and field and register widths
  localparam int stop_idle_pos = 13;
  localparam int abort_pos = 12;
  localparam int req_mode_lsb = 8;
  localparam int cur_mode_lsb = 5;
  localparam int capture_pos = 3;
  localparam int window_pos = 0;
  localparam int mask_width = 10;
  localparam int reg_width = 16;
  localparam int mode_width = 3;
  // Values after reset
  localparam logic [15:0] ctrl_reset = 16'h0480;
  localparam logic [9:0] mask_reset = 10'h000;
  localparam logic [2:0] mode_config = 3'h4;
  // Cycles a mode change takes to settle
  localparam int mode_settle_cycles = 4;
  // Operating modes
  typedef enum logic [2:0] {
    mode_normal = 3'h0,
    mode_disable = 3'h1,
    mode_loopback = 3'h2,
    mode_listen_only = 3'h3,
    mode_configuration = 3'h4,
    mode_rsvd_a = 3'h5,
    mode_rsvd_b = 3'h6,
    mode_listen_all = 3'h7
  } op_mode_t;
endpackage

/* rtl/mask_compare.sv */
// Masked address comparison for acceptance
`timescale 1ns/1ps
module mask_compare #(
  parameter int width = 10
) (
  // Operands
  input wire logic [width-1:0] msg_addr,
  input wire logic [width-1:0] filter_addr,
  input wire logic [width-1:0] mask,
  // Result
  output logic hit
);
  // Set mask bit drops that bit from comparison
  assign hit = (((msg_addr ^ filter_addr) & ~mask) == '0);
endmodule // mask_compare

/* verif/testbench.sv */
// Self-checking bench for the mode control block
`timescale 1ns/1ps
module testbench;
  import can_mode_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, device_idle, rx_done, load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, tx_abort, accept_hit, rx_capture_event, controller_halt;
  logic filter_window, err;
  logic [7:0] tx_pending;
  logic [9:0] msg_addr, filter_addr;
  logic [2:0] current_op_mode;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  int mismatches = 0;
  int comparisons = 0;
  can_mode_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_idle(device_idle), .tx_pending(tx_pending),
    .tx_abort(tx_abort), .rx_done(rx_done), .msg_addr(msg_addr), .filter_addr(filter_addr),
    .accept_hit(accept_hit), .rx_capture_event(rx_capture_event),
    .current_op_mode(current_op_mode), .controller_halt(controller_halt),
    .filter_window(filter_window));
  tx_buffer_model model (.pclk(pclk), .presetn(presetn), .load(load), .tx_abort(tx_abort),
    .tx_pending(tx_pending));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200_000;
    mismatches++;
    close_out();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, device_idle, rx_done, load} = 7'h00;
    {paddr, pwdata, msg_addr, filter_addr} = '0;
    pstrb = 4'hf;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, ctrl_one_offset, '0);
    chk(rd, 32'h0000_0480);
    xfer(1'b0, mask_offset, '0);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, mask_offset, 32'hffff_ffff);
    xfer(1'b0, mask_offset, '0);
    chk(rd, 32'h0000_03ff);
    msg_addr <= 10'h201;
    filter_addr <= 10'h000;
    cycles(2);
    chk(accept_hit, 1'b1);
    xfer(1'b1, mask_offset, 32'h0000_0001);
    cycles(2);
    chk(accept_hit, 1'b0);
    xfer(1'b1, mask_offset, 32'h0000_0201);
    cycles(2);
    chk(accept_hit, 1'b1);
    xfer(1'b0, 12'h00c, '0);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, ctrl_one_offset, 32'(codes[i]) << 8);
      cycles(mode_settle_cycles - 1);
      chk(current_op_mode, i == 0 ? mode_config : codes[i - 1]);
      cycles(1);
      chk(current_op_mode, codes[i]);
      xfer(1'b0, ctrl_one_offset, '0);
      chk(rd, (32'(codes[i]) << 8) | (32'(codes[i]) << 5));
    end
    xfer(1'b1, ctrl_one_offset, 32'h0000_c416);
    xfer(1'b0, ctrl_one_offset, '0);
    chk(rd, 32'h0000_0480);
    xfer(1'b1, ctrl_one_offset, 32'h0000_0409);
    cycles(1);
    chk(filter_window, 1'b1);
    for (int c = 0; c < 2; c++) begin
      @(posedge pclk);
      rx_done <= 1'b1;
      @(posedge pclk);
      rx_done <= 1'b0;
      #1;
      chk(rx_capture_event, c == 0);
      xfer(1'b1, ctrl_one_offset, 32'h0000_0400);
    end
    chk(filter_window, 1'b0);
    @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    xfer(1'b1, ctrl_one_offset, 32'h0000_1480);
    cycles(1);
    chk(tx_abort, 1'b1);
    xfer(1'b0, ctrl_one_offset, '0);
    chk(rd, 32'h0000_1480);
    for (int n = 0; n < 12 && rd[12] !== 1'b0; n++) xfer(1'b0, ctrl_one_offset, '0);
    chk(rd, 32'h0000_0480);
    chk(tx_abort, 1'b0);
    xfer(1'b0, pending_offset, '0);
    chk(rd, 32'h0000_0000);
    device_idle <= 1'b1;
    cycles(5);
    chk(controller_halt, 1'b0);
    xfer(1'b1, ctrl_one_offset, 32'h0000_2488);
    cycles(2);
    chk(controller_halt, 1'b1);
    @(posedge pclk);
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    #1;
    chk(rx_capture_event, 1'b0);
    @(posedge pclk);
    device_idle <= 1'b0;
    cycles(5);
    chk(controller_halt, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(current_op_mode, mode_config);
    xfer(1'b0, ctrl_one_offset, '0);
    chk(rd, 32'h0000_0480);
    xfer(1'b0, mask_offset, '0);
    chk(rd, 32'h0000_0000);
    close_out();
  end
endmodule // testbench

/* verif/tx_buffer_model.sv */
// Transmit buffer model that drops pending frames on abort
`timescale 1ns/1ps
module tx_buffer_model #(
  parameter int drain_cycles = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic tx_abort,
  output logic [7:0] tx_pending
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pending <= 8'h00;
      cnt <= 0;
    end else if (load) begin
      tx_pending <= 8'h0f;
    end else if (tx_abort && tx_pending != 8'h00) begin
      cnt <= cnt + 1;
      if (cnt == drain_cycles) begin // Slow drain, then all frames abandoned
        tx_pending <= 8'h00;
        cnt <= 0;
      end
    end
  end
endmodule // tx_buffer_model
